/* File: mac_regs_pkg.sv */
// Package: offsets, field layouts and carriers of the station address
// table and DMA pointer register bank. Needs nothing from outside.
package mac_regs_pkg;

    // Register byte offsets on the AXI4-Lite bus
    localparam logic [11:0] OFS_ADDR_LOW = 12'h000;
    localparam logic [11:0] OFS_ADDR_HIGH = 12'h004;
    localparam logic [11:0] OFS_INDEX = 12'h008;
    localparam logic [11:0] OFS_HEAD_ERR = 12'h00c;
    localparam logic [11:0] OFS_INT_PEND = 12'h010;
    // Banks of eight channel words, decoded on address bits 11-5
    localparam logic [6:0] BANK_TX_HEAD = 7'h08;
    localparam logic [6:0] BANK_RX_HEAD = 7'h09;
    localparam logic [6:0] BANK_TX_CP = 7'h0a;
    localparam logic [6:0] BANK_RX_CP = 7'h0b;

    // Field positions
    localparam int LOW_BYTE0_LSB = 8;
    localparam int LOW_BYTE1_LSB = 0;
    localparam int INDEX_W = 3;
    localparam int GROUP_BIT = 0;

    // Reset values
    localparam logic [31:0] ADDR_HIGH_RST = 32'h0000_0000;
    localparam logic [7:0] ADDR_BYTE_RST = 8'h00;
    localparam logic [31:0] PTR_RST = 32'h0000_0000;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Completion report from the DMA engine: channel hit bits plus address
    typedef struct packed {
        logic [7:0] hit;
        logic [31:0] addr;
    } dma_done_t;

    // Upper 40 address bits shared by every table entry
    typedef struct packed {
        logic [31:0] high;
        logic [7:0] byte_one;
    } station_upper_t;

endpackage : mac_regs_pkg

/* File: dma_channel_ptr.sv */
// One DMA channel: head pointer, completion pointer, pending interrupt.
// Assumes writes arrive as single-cycle strobes from the register bank.
`timescale 1ns/100ps
`default_nettype none
module dma_channel_ptr (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Register writes
    input wire logic head_wr,
    input wire logic cp_wr,
    input wire logic [31:0] wdata,
    // DMA engine side
    input wire logic done,
    input wire logic [31:0] done_addr,
    input wire logic head_clr,
    // State out
    output logic [31:0] head_q,
    output logic [31:0] cp_q,
    output logic pend_q,
    output logic start_q,
    output logic err_q
);

    logic [31:0] last_q;
    logic head_busy;
    logic head_take;
    logic cp_match;
    logic pend_d;

    // A write to a busy head pointer is refused and flagged
    assign head_busy = (head_q != mac_regs_pkg::PTR_RST);
    assign head_take = head_wr & ~head_busy;
    assign cp_match = cp_wr & (wdata == last_q);
    // New completion wins over an acknowledge in the same cycle
    assign pend_d = done ? 1'b1 : (cp_match ? 1'b0 : pend_q); // [RULE13] [RULE14]

    // Pointer and interrupt state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            head_q <= mac_regs_pkg::PTR_RST;
            cp_q <= mac_regs_pkg::PTR_RST;
            last_q <= mac_regs_pkg::PTR_RST;
            pend_q <= 1'b0;
            start_q <= 1'b0;
            err_q <= 1'b0;
        end
        else if (ce)
        begin
            start_q <= head_take; // [RULE8] [RULE9]
            err_q <= head_wr & head_busy; // [RULE10]
            if (head_take)
                head_q <= wdata;
            else if (head_clr)
                head_q <= mac_regs_pkg::PTR_RST;
            if (cp_wr)
                cp_q <= wdata; // [RULE12]
            if (done)
                last_q <= done_addr;
            pend_q <= pend_d;
        end
    end

endmodule : dma_channel_ptr
`default_nettype wire

/* File: mac_addr_table_dma_pointers.sv */
// Register bank of the ethernet_controller: station address table loaded
// through an index register, and per-channel DMA head and completion
// pointers. Assumes an AXI4-Lite master on aclk and a DMA engine that
// reports completions and clears head pointers at end of queue.
//
// Behaviour
// RULE1: Low register: byte 0 in bits 15-8, byte 1 in 7-0, upper half zero.
// RULE2: High register holds bytes 2,3,4,5 in bits 31-24,23-16,15-8,7-0.
// RULE3: Group bit 40 is stored as zero and always reads as zero.
// RULE4: Eight entries share upper 40 bits; only byte 0 is per entry.
// RULE5: Index register bits 2-0 choose entry 0 to 7 for low writes.
// RULE6: Host writes index, then high register, then low register.
// RULE7: Host may write the high register once, before the first entry.
// RULE8: Writing a transmit head pointer starts that channel's transmit DMA.
// RULE9: Writing a receive head pointer enables that channel's receive DMA.
// RULE10: Writing a nonzero head pointer is an error.
// RULE11: Host clears every head pointer to zero after reset.
// RULE12: Host writes each completion pointer with its last processed descriptor.
// RULE13: Completion pointer write decides whether the channel interrupt drops.
// RULE14: Interrupt drops when completion pointer equals last completed descriptor.
`timescale 1ns/100ps
`default_nettype none
module mac_addr_table_dma_pointers #(
    parameter int NUM_CH = 8,
    parameter int NUM_ENTRY = 8
) (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [11:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [11:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Station address table towards the matcher
    output mac_regs_pkg::station_upper_t station_upper,
    output logic [8*NUM_ENTRY-1:0] station_byte_zero,
    // DMA engine: completions and end-of-queue clears
    input wire mac_regs_pkg::dma_done_t tx_done,
    input wire mac_regs_pkg::dma_done_t rx_done,
    input wire logic [NUM_CH-1:0] tx_head_clr,
    input wire logic [NUM_CH-1:0] rx_head_clr,
    // DMA engine: pointers and commands
    output logic [32*NUM_CH-1:0] tx_head_bus,
    output logic [32*NUM_CH-1:0] rx_head_bus,
    output logic [NUM_CH-1:0] tx_dma_start,
    output logic [NUM_CH-1:0] rx_dma_start,
    // Per-channel interrupt lines
    output logic [NUM_CH-1:0] tx_int,
    output logic [NUM_CH-1:0] rx_int
);

    localparam int IW = mac_regs_pkg::INDEX_W;
    localparam int L0 = mac_regs_pkg::LOW_BYTE0_LSB;
    localparam int L1 = mac_regs_pkg::LOW_BYTE1_LSB;

    // Bus handshake state
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // Address table storage
    logic [31:0] addr_high_q;
    logic [7:0] byte_one_q;
    logic [7:0] byte_zero_q [NUM_ENTRY];
    logic [IW-1:0] index_q;

    // Sticky head-write error flags, transmit in 7-0, receive in 15-8
    logic [2*NUM_CH-1:0] head_err_q;

    // Channel state gathered from the channel instances
    logic [31:0] tx_head [NUM_CH];
    logic [31:0] rx_head [NUM_CH];
    logic [31:0] tx_cp [NUM_CH];
    logic [31:0] rx_cp [NUM_CH];
    logic [NUM_CH-1:0] tx_pend;
    logic [NUM_CH-1:0] rx_pend;
    logic [NUM_CH-1:0] tx_start;
    logic [NUM_CH-1:0] rx_start;
    logic [NUM_CH-1:0] tx_err;
    logic [NUM_CH-1:0] rx_err;

    // Bus outputs come straight from their flops
    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    // Write acceptance: address and data are taken together in one beat,
    // which keeps one write in flight and avoids a holding register.
    logic aw_offer;
    logic wr_fire;
    logic wr_full;
    assign aw_offer = awvalid & wvalid & ~awready_q & ~bvalid_q;
    assign wr_fire = awready_q & awvalid & wvalid;
    assign wr_full = (wstrb == 4'hf);

    // Write address decode
    logic [6:0] wbank;
    logic [IW-1:0] wch;
    logic w_aligned;
    logic w_low;
    logic w_high;
    logic w_index;
    logic w_err;
    logic w_pend;
    logic w_txh;
    logic w_rxh;
    logic w_txc;
    logic w_rxc;
    logic w_hit;
    logic wr_en;
    assign wbank = awaddr[11:5];
    assign wch = awaddr[2 +: IW];
    assign w_aligned = (awaddr[1:0] == 2'h0);
    assign w_low = (awaddr == mac_regs_pkg::OFS_ADDR_LOW);
    assign w_high = (awaddr == mac_regs_pkg::OFS_ADDR_HIGH);
    assign w_index = (awaddr == mac_regs_pkg::OFS_INDEX);
    assign w_err = (awaddr == mac_regs_pkg::OFS_HEAD_ERR);
    assign w_pend = (awaddr == mac_regs_pkg::OFS_INT_PEND);
    assign w_txh = w_aligned & (wbank == mac_regs_pkg::BANK_TX_HEAD);
    assign w_rxh = w_aligned & (wbank == mac_regs_pkg::BANK_RX_HEAD);
    assign w_txc = w_aligned & (wbank == mac_regs_pkg::BANK_TX_CP);
    assign w_rxc = w_aligned & (wbank == mac_regs_pkg::BANK_RX_CP);
    assign w_hit = w_low | w_high | w_index | w_err | w_pend
        | w_txh | w_rxh | w_txc | w_rxc;
    // Partial writes are refused whole, so a pointer is never half updated
    assign wr_en = wr_fire & wr_full & w_hit;

    // Write strobes towards the channels, one-hot on the channel number
    logic [NUM_CH-1:0] ch_sel;
    logic [NUM_CH-1:0] txh_wr;
    logic [NUM_CH-1:0] rxh_wr;
    logic [NUM_CH-1:0] txc_wr;
    logic [NUM_CH-1:0] rxc_wr;
    assign ch_sel = NUM_CH'(1) << wch;
    assign txh_wr = (wr_en & w_txh) ? ch_sel : '0;
    assign rxh_wr = (wr_en & w_rxh) ? ch_sel : '0;
    assign txc_wr = (wr_en & w_txc) ? ch_sel : '0;
    assign rxc_wr = (wr_en & w_rxc) ? ch_sel : '0;

    // Write response channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= mac_regs_pkg::RESP_OKAY;
        end
        else if (ce)
        begin
            awready_q <= aw_offer;
            wready_q <= aw_offer;
            if (wr_fire)
            begin
                bvalid_q <= 1'b1;
                bresp_q <= (wr_full & w_hit) ? mac_regs_pkg::RESP_OKAY
                                             : mac_regs_pkg::RESP_SLVERR;
            end
            else if (bready)
                bvalid_q <= 1'b0;
        end
    end

    // Address table write data, group bit forced clear on the way in
    logic [31:0] high_wval;
    assign high_wval = wdata & ~(32'h1 << mac_regs_pkg::GROUP_BIT); // [RULE3]

    // Shared upper bits, shared byte one and index
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            addr_high_q <= mac_regs_pkg::ADDR_HIGH_RST;
            byte_one_q <= mac_regs_pkg::ADDR_BYTE_RST;
            index_q <= '0;
        end
        else if (ce & wr_en)
        begin
            if (w_high)
                addr_high_q <= high_wval; // [RULE2] [RULE4]
            if (w_low)
                byte_one_q <= wdata[L1 +: 8]; // [RULE1] [RULE4]
            if (w_index)
                index_q <= wdata[IW-1:0]; // [RULE5]
        end
    end

    // Per-entry byte zero, each entry written only when the index selects it
    genvar e;
    generate
        for (e = 0; e < NUM_ENTRY; e++)
        begin : g_entry
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    byte_zero_q[e] <= mac_regs_pkg::ADDR_BYTE_RST;
                else if (ce & wr_en & w_low & (index_q == IW'(e)))
                    byte_zero_q[e] <= wdata[L0 +: 8]; // [RULE1] [RULE5]
            end
            assign station_byte_zero[8*e +: 8] = byte_zero_q[e];
        end
    endgenerate

    assign station_upper.high = addr_high_q;
    assign station_upper.byte_one = byte_one_q;

    // Channel pointer instances, transmit and receive
    genvar c;
    generate
        for (c = 0; c < NUM_CH; c++)
        begin : g_ch
            dma_channel_ptr u_tx (
                .aclk(aclk),
                .aresetn(aresetn),
                .ce(ce),
                .head_wr(txh_wr[c]),
                .cp_wr(txc_wr[c]),
                .wdata(wdata),
                .done(tx_done.hit[c]),
                .done_addr(tx_done.addr),
                .head_clr(tx_head_clr[c]),
                .head_q(tx_head[c]),
                .cp_q(tx_cp[c]),
                .pend_q(tx_pend[c]),
                .start_q(tx_start[c]),
                .err_q(tx_err[c])
            );
            dma_channel_ptr u_rx (
                .aclk(aclk),
                .aresetn(aresetn),
                .ce(ce),
                .head_wr(rxh_wr[c]),
                .cp_wr(rxc_wr[c]),
                .wdata(wdata),
                .done(rx_done.hit[c]),
                .done_addr(rx_done.addr),
                .head_clr(rx_head_clr[c]),
                .head_q(rx_head[c]),
                .cp_q(rx_cp[c]),
                .pend_q(rx_pend[c]),
                .start_q(rx_start[c]),
                .err_q(rx_err[c])
            );
            assign tx_head_bus[32*c +: 32] = tx_head[c]; // [RULE8]
            assign rx_head_bus[32*c +: 32] = rx_head[c]; // [RULE9]
        end
    endgenerate

    assign tx_dma_start = tx_start;
    assign rx_dma_start = rx_start;
    assign tx_int = tx_pend; // [RULE13]
    assign rx_int = rx_pend; // [RULE13]

    // Error flags: write one to clear, a new error in that cycle wins
    logic [2*NUM_CH-1:0] err_set;
    logic [2*NUM_CH-1:0] err_clr;
    assign err_set = {rx_err, tx_err}; // [RULE10]
    assign err_clr = (wr_en & w_err) ? wdata[2*NUM_CH-1:0] : '0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            head_err_q <= '0;
        else if (ce)
            head_err_q <= (head_err_q & ~err_clr) | err_set;
    end

    // Read acceptance: one read in flight, answered the cycle after
    logic ar_offer;
    logic rd_fire;
    assign ar_offer = arvalid & ~arready_q & ~rvalid_q;
    assign rd_fire = arready_q & arvalid;

    // Read address decode
    logic [6:0] rbank;
    logic [IW-1:0] rch;
    logic r_aligned;
    logic r_low;
    logic r_high;
    logic r_index;
    logic r_err;
    logic r_pend;
    logic r_txh;
    logic r_rxh;
    logic r_txc;
    logic r_rxc;
    logic r_hit;
    assign rbank = araddr[11:5];
    assign rch = araddr[2 +: IW];
    assign r_aligned = (araddr[1:0] == 2'h0);
    assign r_low = (araddr == mac_regs_pkg::OFS_ADDR_LOW);
    assign r_high = (araddr == mac_regs_pkg::OFS_ADDR_HIGH);
    assign r_index = (araddr == mac_regs_pkg::OFS_INDEX);
    assign r_err = (araddr == mac_regs_pkg::OFS_HEAD_ERR);
    assign r_pend = (araddr == mac_regs_pkg::OFS_INT_PEND);
    assign r_txh = r_aligned & (rbank == mac_regs_pkg::BANK_TX_HEAD);
    assign r_rxh = r_aligned & (rbank == mac_regs_pkg::BANK_RX_HEAD);
    assign r_txc = r_aligned & (rbank == mac_regs_pkg::BANK_TX_CP);
    assign r_rxc = r_aligned & (rbank == mac_regs_pkg::BANK_RX_CP);
    assign r_hit = r_low | r_high | r_index | r_err | r_pend
        | r_txh | r_rxh | r_txc | r_rxc;

    // Register views; reserved bits read as zero
    logic [31:0] low_view;
    logic [31:0] index_view;
    logic [31:0] err_view;
    logic [31:0] pend_view;
    logic [31:0] rd_mux;
    assign low_view = {16'h0000, byte_zero_q[index_q], byte_one_q}; // [RULE1]
    assign index_view = {{(32-IW){1'b0}}, index_q}; // [RULE5]
    assign err_view = {{(32-2*NUM_CH){1'b0}}, head_err_q};
    assign pend_view = {{(32-2*NUM_CH){1'b0}}, rx_pend, tx_pend};
    assign rd_mux = r_low ? low_view :
                    r_high ? addr_high_q : // [RULE3]
                    r_index ? index_view :
                    r_err ? err_view :
                    r_pend ? pend_view :
                    r_txh ? tx_head[rch] :
                    r_rxh ? rx_head[rch] :
                    r_txc ? tx_cp[rch] :
                    r_rxc ? rx_cp[rch] : 32'h0000_0000;

    // Read data channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= mac_regs_pkg::RESP_OKAY;
        end
        else if (ce)
        begin
            arready_q <= ar_offer;
            if (rd_fire)
            begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_mux;
                rresp_q <= r_hit ? mac_regs_pkg::RESP_OKAY
                                 : mac_regs_pkg::RESP_SLVERR;
            end
            else if (rready)
                rvalid_q <= 1'b0;
        end
    end

endmodule : mac_addr_table_dma_pointers
`default_nettype wire

/* File: mac_regs_chk.sv */
// Checker of the register bank, watching its ports.
// Assumes it sees only top-level ports; bound below.
`timescale 1ns/100ps
`default_nettype none
module mac_regs_chk #(
    parameter int NUM_CH = 8,
    parameter int NUM_ENTRY = 8
) (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Bus handshakes
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    // Table and DMA side
    input wire mac_regs_pkg::station_upper_t station_upper,
    input wire mac_regs_pkg::dma_done_t tx_done,
    input wire logic [NUM_CH-1:0] tx_head_clr,
    input wire logic [32*NUM_CH-1:0] tx_head_bus,
    input wire logic [32*NUM_CH-1:0] rx_head_bus,
    input wire logic [NUM_CH-1:0] tx_dma_start,
    input wire logic [NUM_CH-1:0] rx_dma_start,
    input wire logic [NUM_CH-1:0] tx_int,
    input wire logic [NUM_CH-1:0] rx_int
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Bus answers one cycle after taking and holds until accepted
    a_wr_answer: assert property (ce && awvalid && awready && wvalid |=> bvalid)
        else $error("no write response");
    a_b_stands: assert property (ce && bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    a_rd_answer: assert property (ce && arvalid && arready |=> rvalid)
        else $error("no read data");
    a_r_stands: assert property (ce && rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    a_group_zero: assert property (station_upper.high[mac_regs_pkg::GROUP_BIT] == 1'b0)
        else $error("group bit stored as one");
    // Transmit interrupts rise on completion, any interrupt drops only on a register write
    a_int_on_done: assert property (ce && tx_done.hit != 0 |=>
        (tx_int & $past(tx_done.hit)) == $past(tx_done.hit)) else $error("tx interrupt missing");
    a_int_drop_wr: assert property ((($past({rx_int, tx_int}) & ~{rx_int, tx_int}) != 0)
        |-> $past(awvalid && awready && wvalid)) else $error("interrupt dropped without write");

    // Per channel: arming starts the queue, a busy transmit head stays
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_ch
        a_tx_start: assert property ($rose(tx_head_bus[32*c +: 32] != 32'h0)
            |-> tx_dma_start[c]) else $error("tx start pulse missing");
        a_rx_start: assert property ($rose(rx_head_bus[32*c +: 32] != 32'h0)
            |-> rx_dma_start[c]) else $error("rx start pulse missing");
        a_head_held: assert property (ce && tx_head_bus[32*c +: 32] != 32'h0
            && !tx_head_clr[c] |=> $stable(tx_head_bus[32*c +: 32]))
            else $error("busy head overwritten");
    end

    // Main scenarios reached
    c_write: cover property (ce && awvalid && awready && wvalid);
    c_int_drop: cover property (tx_int == 0 && $past(tx_int) != 0);
    c_refused: cover property (bvalid && bresp == mac_regs_pkg::RESP_SLVERR);
endmodule : mac_regs_chk

bind mac_addr_table_dma_pointers mac_regs_chk #(.NUM_CH(NUM_CH), .NUM_ENTRY(NUM_ENTRY)) i_chk (
    .aclk, .aresetn, .ce, .awvalid, .awready, .wvalid, .bvalid, .bready, .bresp, .arvalid,
    .arready, .rvalid, .rready, .rdata, .station_upper, .tx_done, .tx_head_clr,
    .tx_head_bus, .rx_head_bus, .tx_dma_start, .rx_dma_start, .tx_int, .rx_int);
`default_nettype wire

/* File: host_axi_model.sv */
// Host model: AXI4-Lite master, one word per access.
// Assumes a slave on aclk; waits for every answer.
`timescale 1ns/100ps
`default_nettype none
module host_axi_model (
    // Clock
    input wire logic aclk,
    // Write channels
    output var logic awvalid,
    input wire logic awready,
    output var logic [11:0] awaddr,
    output var logic wvalid,
    input wire logic wready,
    output var logic [31:0] wdata,
    output var logic [3:0] wstrb,
    input wire logic bvalid,
    output var logic bready,
    // Read channels
    output var logic arvalid,
    input wire logic arready,
    output var logic [11:0] araddr,
    input wire logic rvalid,
    output var logic rready
);
    // Idle bus at time zero
    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, wdata, wstrb, araddr} = '0;
    end

    // Address and data offered together, held until taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw_left = 1'b1, w_left = 1'b1;
        @(posedge aclk);
        {awaddr, wdata, wstrb} <= {a, d, s};
        {awvalid, wvalid, bready} <= 3'b111;
        while (aw_left | w_left)
        begin
            @(posedge aclk);
            aw_left &= awready !== 1'b1;
            w_left &= wready !== 1'b1;
            {awvalid, wvalid} <= {aw_left, w_left};
        end
        {awaddr, wdata} <= {~a, ~d}; // Released payload must not look valid
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask : wr

    // Read address held until taken, rready until data seen
    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        araddr <= ~a;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask : rd
endmodule : host_axi_model
`default_nettype wire

/* File: test_mac_addr_table_dma_pointers.sv */
// Bench: host model on the bus, DMA pulses here.
// Assumes bus answers come back in issue order.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED at %0t got %h exp %h", $time, (g), (e)); end end
module test_mac_addr_table_dma_pointers;
    localparam logic [1:0] OK = mac_regs_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = mac_regs_pkg::RESP_SLVERR;
    logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, eb;
    logic [33:0] er;
    mac_regs_pkg::station_upper_t station_upper;
    mac_regs_pkg::dma_done_t tx_done, rx_done;
    logic [63:0] station_byte_zero;
    logic [7:0] tx_head_clr, rx_head_clr, tx_dma_start, rx_dma_start, tx_int, rx_int;
    logic [255:0] tx_head_bus, rx_head_bus;
    int n_errors = 0;
    int total_checks = 0;
    logic [33:0] exp_r [$];
    logic [1:0] exp_b [$];

    mac_addr_table_dma_pointers i_dut (.aclk, .aresetn, .ce,
        .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready,
        .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
        .station_upper, .station_byte_zero, .tx_done, .rx_done, .tx_head_clr,
        .rx_head_clr, .tx_head_bus, .rx_head_bus, .tx_dma_start, .rx_dma_start, .tx_int,
        .rx_int);
    host_axi_model i_host (.aclk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
        .wstrb, .bvalid, .bready, .arvalid, .arready, .araddr, .rvalid, .rready);

    // Clock at 100 ns
    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // Queue the answer, then access
    task automatic wr_chk(input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s = 4'hf, input logic [1:0] r = OK);
        exp_b.push_back(r);
        i_host.wr(a, d, s);
    endtask : wr_chk
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = OK);
        exp_r.push_back({r, d});
        i_host.rd(a);
    endtask : rd_chk

    // One-cycle DMA completion or end-of-queue pulse
    task automatic dma_pulse(input int d, input int c, input logic [31:0] a, input bit clr);
        @(posedge aclk);
        if (clr)
            {rx_head_clr, tx_head_clr} <= 16'(1 << (c + 8 * d));
        else if (d == 0)
            tx_done <= {8'(1 << c), a};
        else
            rx_done <= {8'(1 << c), a};
        @(posedge aclk);
        {rx_head_clr, tx_head_clr, tx_done, rx_done} <= '0;
        repeat (2) @(posedge aclk);
    endtask : dma_pulse

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up

    // Monitor: answers against the oldest note
    always @(posedge aclk)
    begin
        if (bvalid === 1'b1 && bready === 1'b1)
        begin
            eb = exp_b.pop_front();
            `CHK(bresp, eb)
        end
        if (rvalid === 1'b1 && rready === 1'b1)
        begin
            er = exp_r.pop_front();
            `CHK({rresp, rdata}, er)
        end
    end

    // Watchdog, well past the expected run
    initial
    begin
        repeat (40000) @(posedge aclk);
        n_errors++;
        wrap_up();
    end

    // Main sequence
    initial
    begin
        int c;
        logic [31:0] p, hi, bit_c;
        logic [7:0] b0 [8];
        logic [7:0] b1;
        logic [11:0] hb;
        ce = 1'b1;
        aresetn = 1'b0;
        {tx_done, rx_done, tx_head_clr, rx_head_clr} = '0;
        void'($urandom(19));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(12'h004, 32'h0);
        for (int i = 0; i < 16; i++)
            wr_chk(12'h100 + 12'(4 * i), 32'h0);
        // Load all entries: index, shared high once, then low
        hi = $urandom | 32'h1;
        for (int e = 0; e < 8; e++)
        begin
            b0[e] = 8'($urandom);
            b1 = 8'($urandom);
            wr_chk(12'h008, {29'($urandom), 3'(e)});
            rd_chk(12'h008, 32'(e));
            if (e == 0)
                wr_chk(12'h004, hi);
            wr_chk(12'h000, {16'($urandom), b0[e], b1});
            rd_chk(12'h000, {16'h0, b0[e], b1});
        end
        rd_chk(12'h004, hi & 32'hffff_fffe);
        `CHK(station_upper, {hi & 32'hffff_fffe, b1})
        for (int e = 0; e < 8; e++)
            `CHK(station_byte_zero[8*e +: 8], b0[e])
        // Unmapped, unaligned and partial accesses are refused
        rd_chk(12'h0f0, 32'h0, ERR);
        rd_chk(12'h006, 32'h0, ERR);
        wr_chk(12'h004, 32'h0, 4'h3, ERR);
        rd_chk(12'h004, hi & 32'hffff_fffe);
        // Per direction: arm, busy rewrite, end of queue, completion
        for (int d = 0; d < 2; d++)
        begin
            c = $urandom_range(7);
            p = ($urandom & 32'hffff_fff0) | 32'h10;
            hb = 12'h100 + 12'(32 * d + 4 * c);
            bit_c = 32'h1 << (c + 8 * d);
            wr_chk(hb, p);
            `CHK(d ? rx_head_bus[32*c +: 32] : tx_head_bus[32*c +: 32], p)
            wr_chk(hb, p ^ 32'h100);
            rd_chk(hb, p);
            rd_chk(12'h00c, bit_c);
            wr_chk(12'h00c, bit_c);
            rd_chk(12'h00c, 32'h0);
            dma_pulse(d, c, p, 1'b1);
            rd_chk(hb, 32'h0);
            dma_pulse(d, c, p, 1'b0);
            `CHK(d ? rx_int[c] : tx_int[c], 1'b1)
            rd_chk(12'h010, bit_c);
            wr_chk(hb + 12'h040, p ^ 32'h40);
            `CHK(d ? rx_int[c] : tx_int[c], 1'b1)
            wr_chk(hb + 12'h040, p);
            `CHK(d ? rx_int[c] : tx_int[c], 1'b0)
            rd_chk(12'h010, 32'h0);
        end
        repeat (4) @(posedge aclk);
        wrap_up();
    end
endmodule : test_mac_addr_table_dma_pointers
`default_nettype wire
